// file: logic/usbc_pkg.sv
// constants, field layout and types for the usb control block
package usbc_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] TOKEN_OFF = 8'h04;

    // usb_control_register field positions
    localparam int MOD_EN_BIT = 0;
    localparam int PP_RESET_BIT = 1;
    localparam int RESUME_BIT = 2;
    localparam int HOST_EN_BIT = 3;
    localparam int BUS_RESET_BIT = 4;
    localparam int PKT_DIS_BIT = 5;
    localparam int LINE_SE0_BIT = 6;
    localparam int LINE_J_BIT = 7;
    localparam int CTRL_USED_W = 8;
    localparam int TOKEN_W = 8;

    // reset values of the writable control fields
    localparam logic MOD_EN_RST = 1'b0;
    localparam logic PP_RESET_RST = 1'b0;
    localparam logic RESUME_RST = 1'b0;
    localparam logic HOST_EN_RST = 1'b0;
    localparam logic BUS_RESET_RST = 1'b0;
    localparam logic PKT_DIS_RST = 1'b0;
    localparam logic [7:0] TOKEN_RST = 8'h00;

    // low-speed end-of-packet timing
    localparam int CLK_MHZ = 40;
    localparam int LS_EOP_SE0_NS = 1333;
    localparam int LS_EOP_J_NS = 667;
    localparam int CNT_W = 6;
    localparam logic [5:0] EOP_SE0_CYC =
        6'((LS_EOP_SE0_NS * CLK_MHZ + 999) / 1000);
    localparam logic [5:0] EOP_J_CYC =
        6'((LS_EOP_J_NS * CLK_MHZ + 999) / 1000);

    // end-of-packet sequencer states
    typedef enum logic [2:0] {
        EOP_IDLE = 3'b001,
        EOP_SE0 = 3'b010,
        EOP_J = 3'b100
    } usbc_eop_state_t;
endpackage

// file: logic/usbc_eop_gen.sv
// low-speed end-of-packet sequencer appended after host resume
`timescale 1ns/1ps
module usbc_eop_gen (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // control
    input wire logic start_in,
    input wire logic abort_in,
    // line phases
    output logic se0_out,
    output logic j_out
);
    usbc_pkg::usbc_eop_state_t state_q;
    logic [5:0] cnt_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= usbc_pkg::EOP_IDLE;
            cnt_q <= 6'h00;
        end else if (abort_in) begin
            state_q <= usbc_pkg::EOP_IDLE;
            cnt_q <= 6'h00;
        end else begin
            unique case (state_q)
                usbc_pkg::EOP_IDLE: begin
                    if (start_in) begin
                        state_q <= usbc_pkg::EOP_SE0;
                        cnt_q <= usbc_pkg::EOP_SE0_CYC - 6'h01;
                    end
                end
                usbc_pkg::EOP_SE0: begin
                    if (cnt_q == 6'h00) begin
                        state_q <= usbc_pkg::EOP_J;
                        cnt_q <= usbc_pkg::EOP_J_CYC - 6'h01;
                    end else begin
                        cnt_q <= cnt_q - 6'h01;
                    end
                end
                usbc_pkg::EOP_J: begin
                    if (cnt_q == 6'h00) begin
                        state_q <= usbc_pkg::EOP_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 6'h01;
                    end
                end
                default: begin
                    state_q <= usbc_pkg::EOP_IDLE;
                end
            endcase
        end
    end

    assign se0_out = (state_q == usbc_pkg::EOP_SE0);
    assign j_out = (state_q == usbc_pkg::EOP_J);
endmodule // usbc_eop_gen

// file: logic/usbc_ctrl.sv
// usb module control register, live line status and line drive
`timescale 1ns/1ps
// Contract
// - live j state flag readable
// - live single-ended zero flag readable
// - device setup token sets processing disable
// - host mode bit five shows token busy
// - host bus reset bit drives reset
// - host enable bit, reset value zero
// - host enable change resets host logic
// - resume bit drives resume signalling
// - host resume clear appends low-speed eop
// - upper bits read as zero
module usbc_ctrl (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // receiver and protocol engine
    input wire logic dp_in,
    input wire logic dm_in,
    input wire logic setup_token_in,
    input wire logic token_done_in,
    // line driver
    output logic line_oe_out,
    output logic line_dp_out,
    output logic line_dm_out,
    // module control
    output logic module_enable_device_out,
    output logic frame_start_generate_enable_out,
    output logic pingpong_pointer_reset_out,
    output logic processing_suspend_out,
    output logic host_mode_out,
    output logic host_logic_reset_out,
    output logic token_start_out,
    output logic [7:0] token_cmd_out
);
    logic line_j_q;
    logic line_se0_q;
    logic mod_en_q;
    logic pp_reset_q;
    logic resume_q;
    logic host_en_q;
    logic bus_rst_q;
    logic pkt_dis_q;
    logic tok_busy_q;
    logic [7:0] token_q;
    logic token_start_q;
    logic host_rst_q;
    logic eop_start_q;
    logic eop_se0;
    logic eop_j;
    logic [31:0] rdata_q;
    logic oe_q;
    logic dp_q;
    logic dm_q;
    logic mod_en_out_q;
    logic sof_en_out_q;
    logic suspend_q;
    logic ctrl_wr;
    logic token_wr;
    logic host_toggle;
    logic [31:0] ctrl_val;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    assign ctrl_wr = wr_in && hit(addr_in, usbc_pkg::CTRL_OFF);
    assign token_wr = wr_in && hit(addr_in, usbc_pkg::TOKEN_OFF);
    assign host_toggle = ctrl_wr &&
        (wdata_in[usbc_pkg::HOST_EN_BIT] != host_en_q);

    // live line state; inputs already synchronous to clk_in
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            line_j_q <= 1'b0;
            line_se0_q <= 1'b0;
        end else begin
            line_j_q <= dp_in && !dm_in;
            line_se0_q <= !dp_in && !dm_in;
        end
    end

    // plain software control bits
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mod_en_q <= usbc_pkg::MOD_EN_RST;
            pp_reset_q <= usbc_pkg::PP_RESET_RST;
            resume_q <= usbc_pkg::RESUME_RST;
            host_en_q <= usbc_pkg::HOST_EN_RST;
        end else if (ctrl_wr) begin
            mod_en_q <= wdata_in[usbc_pkg::MOD_EN_BIT];
            pp_reset_q <= wdata_in[usbc_pkg::PP_RESET_BIT];
            resume_q <= wdata_in[usbc_pkg::RESUME_BIT];
            host_en_q <= wdata_in[usbc_pkg::HOST_EN_BIT];
        end
    end

    // bus reset request is host logic, so a mode change drops it
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_rst_q <= usbc_pkg::BUS_RESET_RST;
        end else if (host_toggle) begin
            bus_rst_q <= 1'b0;
        end else if (ctrl_wr && host_en_q) begin
            bus_rst_q <= wdata_in[usbc_pkg::BUS_RESET_BIT];
        end
    end

    // setup arrival wins over a software clear in the same cycle
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pkt_dis_q <= usbc_pkg::PKT_DIS_RST;
        end else if (setup_token_in && !host_en_q) begin
            pkt_dis_q <= 1'b1;
        end else if (ctrl_wr && !host_en_q) begin
            pkt_dis_q <= wdata_in[usbc_pkg::PKT_DIS_BIT];
        end
    end

    // a new token write wins over a completion in the same cycle
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tok_busy_q <= 1'b0;
        end else if (host_toggle) begin
            tok_busy_q <= 1'b0;
        end else if (token_wr && host_en_q) begin
            tok_busy_q <= 1'b1;
        end else if (token_done_in) begin
            tok_busy_q <= 1'b0;
        end
    end

    // token command; overwrite while busy is the caller's fault
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            token_q <= usbc_pkg::TOKEN_RST;
            token_start_q <= 1'b0;
        end else begin
            token_start_q <= token_wr && host_en_q && !host_toggle;
            if (token_wr) begin
                token_q <= wdata_in[7:0];
            end
        end
    end

    // one-cycle host reset pulse, and eop start on host resume clear
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            host_rst_q <= 1'b0;
            eop_start_q <= 1'b0;
        end else begin
            host_rst_q <= host_toggle;
            eop_start_q <= ctrl_wr && host_en_q && !host_toggle &&
                resume_q && !wdata_in[usbc_pkg::RESUME_BIT];
        end
    end

    usbc_eop_gen u_eop (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .start_in(eop_start_q),
        .abort_in(host_rst_q),
        .se0_out(eop_se0),
        .j_out(eop_j)
    );

    // line drive: reset over eop over resume; full-speed polarity
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            oe_q <= 1'b0;
            dp_q <= 1'b0;
            dm_q <= 1'b0;
        end else if (bus_rst_q && host_en_q) begin
            oe_q <= 1'b1;
            dp_q <= 1'b0;
            dm_q <= 1'b0;
        end else if (eop_se0 || eop_j) begin
            oe_q <= 1'b1;
            dp_q <= eop_j;
            dm_q <= 1'b0;
        end else if (resume_q) begin
            oe_q <= 1'b1;
            dp_q <= 1'b0;
            dm_q <= 1'b1;
        end else begin
            oe_q <= 1'b0;
            dp_q <= 1'b0;
            dm_q <= 1'b0;
        end
    end

    // registered control outputs
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mod_en_out_q <= 1'b0;
            sof_en_out_q <= 1'b0;
            suspend_q <= 1'b0;
        end else begin
            mod_en_out_q <= mod_en_q && !host_en_q;
            sof_en_out_q <= mod_en_q && host_en_q;
            suspend_q <= pkt_dis_q && !host_en_q;
        end
    end

    // read view; bit five changes meaning with the mode
    always_comb begin
        ctrl_val = 32'h0000_0000;
        ctrl_val[usbc_pkg::LINE_J_BIT] = line_j_q;
        ctrl_val[usbc_pkg::LINE_SE0_BIT] = line_se0_q;
        ctrl_val[usbc_pkg::PKT_DIS_BIT] = host_en_q ? tok_busy_q : pkt_dis_q;
        ctrl_val[usbc_pkg::BUS_RESET_BIT] = bus_rst_q;
        ctrl_val[usbc_pkg::HOST_EN_BIT] = host_en_q;
        ctrl_val[usbc_pkg::RESUME_BIT] = resume_q;
        ctrl_val[usbc_pkg::PP_RESET_BIT] = pp_reset_q;
        ctrl_val[usbc_pkg::MOD_EN_BIT] = mod_en_q;
    end

    // read data stand for one cycle only; unmapped reads give zero
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_in && hit(addr_in, usbc_pkg::CTRL_OFF)) begin
            rdata_q <= ctrl_val;
        end else if (rd_in && hit(addr_in, usbc_pkg::TOKEN_OFF)) begin
            rdata_q <= {24'h00_0000, token_q};
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign rdata_out = rdata_q;
    assign line_oe_out = oe_q;
    assign line_dp_out = dp_q;
    assign line_dm_out = dm_q;
    assign module_enable_device_out = mod_en_out_q;
    assign frame_start_generate_enable_out = sof_en_out_q;
    assign pingpong_pointer_reset_out = pp_reset_q;
    assign processing_suspend_out = suspend_q;
    assign host_mode_out = host_en_q;
    assign host_logic_reset_out = host_rst_q;
    assign token_start_out = token_start_q;
    assign token_cmd_out = token_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    logic rd_ctrl;
    assign rd_ctrl = rd_in && hit(addr_in, usbc_pkg::CTRL_OFF);

    a_read_j_flag: assert property (
        rd_ctrl |=> rdata_out[usbc_pkg::LINE_J_BIT] == $past(line_j_q))
        else $error("j flag read mismatch");

    a_read_se0_flag: assert property (
        (!dp_in && !dm_in) ##1 rd_ctrl |=> rdata_out[usbc_pkg::LINE_SE0_BIT])
        else $error("se0 flag not seen on read");

    a_setup_suspends: assert property (
        setup_token_in && !host_en_q |=> ##1 processing_suspend_out)
        else $error("setup did not suspend processing");

    a_busy_read_host: assert property (
        token_wr && host_en_q && !host_toggle ##1 rd_ctrl && host_en_q
        |=> rdata_out[usbc_pkg::PKT_DIS_BIT])
        else $error("token busy not shown after token write");

    a_bus_reset_se0: assert property (
        bus_rst_q && host_en_q |=> line_oe_out && !line_dp_out && !line_dm_out)
        else $error("bus reset not driven");

    a_host_en_write: assert property (
        ctrl_wr |=> host_mode_out == $past(wdata_in[usbc_pkg::HOST_EN_BIT]))
        else $error("host enable did not follow write");

    a_host_toggle_reset: assert property (
        host_toggle |=> host_logic_reset_out && !tok_busy_q && !bus_rst_q)
        else $error("host logic not reset on mode change");

    a_resume_k_drive: assert property (
        resume_q && !(bus_rst_q && host_en_q) && !eop_se0 && !eop_j
        |=> line_oe_out && line_dm_out && !line_dp_out)
        else $error("resume signalling not driven");

    a_eop_after_resume: assert property (
        eop_start_q && !host_rst_q && !bus_rst_q
        |=> ##1 (line_oe_out && !line_dp_out && !line_dm_out) [*8])
        else $error("low-speed eop not appended");

    a_upper_zero: assert property (
        rd_in |=> rdata_out[31:8] == 24'h00_0000)
        else $error("upper bits not zero");

    a_sof_enable: assert property (
        mod_en_q && host_en_q |=> frame_start_generate_enable_out)
        else $error("frame start enable not driven");

    a_busy_done_clear: assert property (
        token_done_in && !token_wr && !host_toggle |=> !tok_busy_q)
        else $error("token busy not cleared by completion");

    a_token_launch: assert property (
        token_wr && host_en_q && !host_toggle
        |=> token_start_out && token_cmd_out == $past(wdata_in[7:0]))
        else $error("token start or command missing");

    a_pkt_dis_clear: assert property (
        ctrl_wr && !host_en_q && !setup_token_in &&
        !wdata_in[usbc_pkg::PKT_DIS_BIT] |=> !pkt_dis_q)
        else $error("packet disable not cleared by write");

    a_bus_rst_refused: assert property (
        ctrl_wr && !host_en_q |=> !bus_rst_q)
        else $error("bus reset accepted in device mode");

    a_eop_j_phase: assert property (
        eop_j && !(bus_rst_q && host_en_q)
        |=> line_oe_out && line_dp_out && !line_dm_out)
        else $error("eop j phase not driven");

    a_pp_reset_write: assert property (
        ctrl_wr |=> pingpong_pointer_reset_out ==
            $past(wdata_in[usbc_pkg::PP_RESET_BIT]))
        else $error("pointer reset did not follow write");

    // idle read port must not leak stale register values
    a_rdata_idle: assert property (
        !rd_in |=> rdata_out == 32'h0000_0000)
        else $error("read data not zero outside a read");

    c_setup_seen: cover property (setup_token_in && !host_en_q);
    c_token_cycle: cover property (token_start_out ##[1:50] token_done_in);
    c_eop_done: cover property (eop_j ##1 !eop_j);
    c_host_toggle: cover property (host_logic_reset_out);
    c_busy_read: cover property (token_start_out && rd_ctrl);
endmodule // usbc_ctrl

// file: testbench/usbc_usb_partner.sv
// far-side usb line model that resolves the shared d+ and d- wires
`timescale 1ns/1ps
module usbc_usb_partner (
    // far-side line state: 0 j, 1 k, 2 se0, 3 released
    input wire logic [1:0] state_in,
    // block line driver
    input wire logic line_oe_in,
    input wire logic line_dp_in,
    input wire logic line_dm_in,
    // resolved wire levels
    output logic dp_out,
    output logic dm_out
);
    logic far_dp;
    logic far_dm;
    always_comb begin
        case (state_in)
            2'h0: {far_dp, far_dm} = 2'b10;
            2'h1: {far_dp, far_dm} = 2'b01;
            2'h2: {far_dp, far_dm} = 2'b00;
            // released: pull-up on d+ leaves the idle level
            default: {far_dp, far_dm} = 2'b10;
        endcase
    end
    // far side lets go while the block drives, so no contention is modelled
    assign dp_out = line_oe_in ? line_dp_in : far_dp;
    assign dm_out = line_oe_in ? line_dm_in : far_dm;
endmodule // usbc_usb_partner

// file: testbench/usb_module_control_tb_top.sv
// self-checking bench for the usb control register block
`timescale 1ns/1ps
module usb_module_control_tb_top;
    localparam logic [7:0] CA = usbc_pkg::CTRL_OFF;
    localparam logic [7:0] TA = usbc_pkg::TOKEN_OFF;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h00000000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic setup_token_in = 1'b0;
    logic token_done_in = 1'b0;
    logic [1:0] far_state = 2'h0;
    logic dp_in, dm_in, line_oe_out, line_dp_out, line_dm_out;
    logic module_enable_device_out, frame_start_generate_enable_out;
    logic pingpong_pointer_reset_out, processing_suspend_out;
    logic host_mode_out, host_logic_reset_out, token_start_out;
    logic [7:0] token_cmd_out;
    logic [31:0] rdata_out;
    logic [31:0] rv;
    logic [2:0] drv;
    int error_cnt = 0;
    int n_tests = 0;
    int n;
    assign drv = {line_oe_out, line_dp_out, line_dm_out};
    always #12.5 clk_in = ~clk_in;

    usbc_ctrl dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .dp_in(dp_in), .dm_in(dm_in),
        .setup_token_in(setup_token_in), .token_done_in(token_done_in),
        .line_oe_out(line_oe_out), .line_dp_out(line_dp_out),
        .line_dm_out(line_dm_out),
        .module_enable_device_out(module_enable_device_out),
        .frame_start_generate_enable_out(frame_start_generate_enable_out),
        .pingpong_pointer_reset_out(pingpong_pointer_reset_out),
        .processing_suspend_out(processing_suspend_out),
        .host_mode_out(host_mode_out),
        .host_logic_reset_out(host_logic_reset_out),
        .token_start_out(token_start_out), .token_cmd_out(token_cmd_out));
    usbc_usb_partner partner_u (.state_in(far_state),
        .line_oe_in(line_oe_out), .line_dp_in(line_dp_out),
        .line_dm_in(line_dm_out), .dp_out(dp_in), .dm_out(dm_in));

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
            input string what);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen,
                exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        rv = rdata_out;
    endtask
    // write then read with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] wa, input logic [31:0] d,
            input logic [7:0] ra);
        @(posedge clk_in);
        addr_in <= wa;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        addr_in <= ra;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        rv = rdata_out;
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    // counts pulse cycles over four cycles; 1 token start, 0 host reset
    task automatic pulse_cnt(input bit tok);
        logic s;
        n = 0;
        repeat (4) begin
            #1;
            s = tok ? token_start_out : host_logic_reset_out;
            n += (s === 1'b1) ? 1 : 0;
            @(posedge clk_in);
        end
    endtask
    // counts cycles the line holds one drive pattern, bounded
    task automatic run_len(input logic [2:0] v);
        n = 0;
        while (n < 200 && drv === v) begin
            n++;
            @(posedge clk_in);
            #1;
        end
    endtask

    task automatic t_reset;
        rd(CA);
        chk(rv, 32'h00000080, "ctrl after reset");
        rd(8'h08);
        chk(rv, 32'h00000000, "unmapped read");
        chk(32'(host_mode_out), 32'h00000000, "host mode off");
        $display("done reset values");
    endtask
    task automatic t_line;
        logic [1:0] exp [3] = '{2'b10, 2'b00, 2'b01};
        for (int s = 0; s < 3; s++) begin
            @(posedge clk_in);
            far_state <= 2'(s);
            cycles(3);
            rd(CA);
            chk(32'(rv[7:6]), 32'(exp[s]), "line flags");
        end
        @(posedge clk_in);
        far_state <= 2'h3;
        $display("done line status");
    endtask
    task automatic t_device;
        wr(CA, 32'h00000013);
        cycles(2);
        chk(32'(module_enable_device_out), 32'h1, "dev enable");
        chk(32'(frame_start_generate_enable_out), 32'h0, "sof");
        chk(32'(pingpong_pointer_reset_out), 32'h1, "pp reset");
        chk(32'(line_oe_out), 32'h0, "no reset in device");
        rd(CA);
        chk(rv, 32'h00000083, "bus reset refused");
        @(posedge clk_in);
        setup_token_in <= 1'b1;
        @(posedge clk_in);
        setup_token_in <= 1'b0;
        cycles(2);
        chk(32'(processing_suspend_out), 32'h1, "suspend");
        rd(CA);
        chk(rv, 32'h000000A3, "pkt disable set");
        wr(CA, 32'h00000003);
        cycles(2);
        chk(32'(processing_suspend_out), 32'h0, "resumed");
        wr(CA, 32'h00000000);
        $display("done device mode");
    endtask
    task automatic t_host;
        wr(CA, 32'h00000009);
        pulse_cnt(1'b0);
        chk(32'(n), 32'h1, "host toggle pulse");
        chk(32'(host_mode_out), 32'h1, "host on");
        chk(32'(frame_start_generate_enable_out), 32'h1, "sof on");
        chk(32'(module_enable_device_out), 32'h0, "dev en off");
        // busy is read and checked clear once, then the token is written without waiting
        rd(CA);
        chk(rv, 32'h00000089, "idle before token");
        wr(TA, 32'h0000005A);
        pulse_cnt(1'b1);
        chk(32'(n), 32'h1, "token start");
        chk(32'(token_cmd_out), 32'h0000005A, "token cmd");
        rd(CA);
        chk(rv, 32'h000000A9, "busy");
        @(posedge clk_in);
        setup_token_in <= 1'b1;
        token_done_in <= 1'b1;
        @(posedge clk_in);
        setup_token_in <= 1'b0;
        token_done_in <= 1'b0;
        cycles(2);
        chk(32'(processing_suspend_out), 32'h0, "no host suspend");
        rd(CA);
        chk(rv, 32'h00000089, "busy clear");
        wr(CA, 32'h00000019);
        cycles(2);
        chk(32'(drv), 32'h4, "bus reset drive");
        rd(CA);
        chk(rv, 32'h00000059, "reset seen as se0");
        wr(CA, 32'h00000009);
        cycles(2);
        chk(32'(line_oe_out), 32'h0, "reset ended");
        wr_rd(TA, 32'h0000003C, CA);
        chk(rv, 32'h000000A9, "busy at once");
        wr(CA, 32'h00000001);
        pulse_cnt(1'b0);
        chk(32'(n), 32'h1, "host off pulse");
        wr(CA, 32'h00000009);
        rd(CA);
        chk(rv, 32'h00000089, "busy cleared by toggle");
        $display("done host mode");
    endtask
    task automatic t_resume;
        // hold shortened from the software figure to keep the run short
        wr(CA, 32'h0000000D);
        cycles(2);
        chk(32'(drv), 32'h5, "host resume drive");
        wr(CA, 32'h00000009);
        n = 0;
        while (n < 8 && drv !== 3'b100) begin
            n++;
            cycles(1);
        end
        chk(32'(n < 8), 32'h1, "eop start seen");
        run_len(3'b100);
        chk(32'(n), 32'(usbc_pkg::EOP_SE0_CYC), "eop se0 len");
        run_len(3'b110);
        chk(32'(n), 32'(usbc_pkg::EOP_J_CYC), "eop j len");
        chk(32'(line_oe_out), 32'h0, "eop released");
        wr(CA, 32'h00000004);
        cycles(2);
        chk(32'(drv), 32'h5, "device resume drive");
        wr(CA, 32'h00000000);
        cycles(3);
        chk(32'(line_oe_out), 32'h0, "no eop in device");
        $display("done resume");
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_line();
        t_device();
        t_host();
        t_resume();
        stop_test();
    end
endmodule // usb_module_control_tb_top
